// ### hw/dwc_decoder.sv
`default_nettype none

module dwc_decoder #(
  parameter int MEM_COLS  = 320,
  parameter int MEM_PAGES = 480
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // Host parallel port
  input  wire logic                       chip_select_n,
  input  wire logic                       data_command_select,
  input  wire logic                       read_strobe_n,
  input  wire logic                       write_strobe_n,
  input  wire logic [dwc_pkg::DATA_W-1:0] host_data,
  // Control from the rest of the device
  input  wire logic                       soft_reset,
  input  wire logic                       row_column_exchange_bit,
  // Panel and window state
  output logic                            display_on,
  output logic      [dwc_pkg::ADDR_W-1:0] column_start,
  output logic      [dwc_pkg::ADDR_W-1:0] column_end,
  output logic      [dwc_pkg::ADDR_W-1:0] page_start,
  output logic      [dwc_pkg::ADDR_W-1:0] page_end,
  output logic                            stream_open,
  // Frame memory write port
  output logic                            pixel_valid,
  output logic      [dwc_pkg::ADDR_W-1:0] pixel_column,
  output logic      [dwc_pkg::ADDR_W-1:0] pixel_page,
  output logic      [dwc_pkg::DATA_W-1:0] pixel_data
);
  import dwc_pkg::*;

  localparam logic [ADDR_W:0] COL_LIMIT  = (ADDR_W+1)'(MEM_COLS);
  localparam logic [ADDR_W:0] PAGE_LIMIT = (ADDR_W+1)'(MEM_PAGES);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Bound fits inside the implemented frame memory on this axis
  function automatic logic bound_ok(input logic [ADDR_W-1:0] v,
                                    input logic [ADDR_W:0]   lim);
    bound_ok = {1'b0, v} < lim;
  endfunction : bound_ok

  function automatic logic [ADDR_W-1:0] join_bound(input logic              hi,
                                                   input logic [CMD_W-1:0] lo);
    join_bound = {hi, lo};
  endfunction : join_bound

  // Next address along one axis; shared by both scan orders
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
    step_addr = a + ADDR_W'(1);
  endfunction : step_addr

  dwc_state_t q;
  dwc_state_t d;

  logic              strobe;
  logic              cmd_strobe;
  logic              data_strobe;
  logic [CMD_W-1:0]  byte_in;
  logic [ADDR_W-1:0] bound_in;
  logic [ADDR_W:0]   col_lim;
  logic [ADDR_W:0]   page_lim;
  logic              col_last;
  logic              page_last;

  // ---------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------
  assign strobe      = write_strobe_n && !q.wr_prev && !chip_select_n
                       && read_strobe_n;
  assign cmd_strobe  = strobe && !data_command_select;
  assign data_strobe = strobe && data_command_select;
  assign byte_in     = host_data[CMD_W-1:0];
  assign bound_in    = join_bound(q.hi_bit, byte_in);
  // Axes swap their extent when rows and columns are exchanged
  assign col_lim     = row_column_exchange_bit ? PAGE_LIMIT : COL_LIMIT;
  assign page_lim    = row_column_exchange_bit ? COL_LIMIT : PAGE_LIMIT;
  assign col_last    = q.cur_col == q.col_end;
  assign page_last   = q.cur_page == q.page_end;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    d.wr_prev   = write_strobe_n;
    d.pix_valid = 1'b0;

    if (cmd_strobe) begin
      // Any command ends a stream and drops a partial parameter set
      d.phase     = DWC_IDLE;
      d.param_idx = PARAM_START_HI;
      case (byte_in)
        CMD_DISPLAY_ON: begin
          d.disp_on = 1'b1;
        end
        CMD_COLUMN_SET: begin
          d.phase = DWC_COLUMN;
        end
        CMD_PAGE_SET: begin
          d.phase = DWC_PAGE;
        end
        CMD_MEM_WRITE: begin
          d.phase    = DWC_STREAM;
          d.cur_col  = q.col_start;
          d.cur_page = q.page_start;
          d.win_done = 1'b0;
        end
        default: begin
          d.phase = DWC_IDLE;
        end
      endcase
    end else if (data_strobe) begin
      case (q.phase)
        DWC_COLUMN, DWC_PAGE: begin
          d.param_idx = q.param_idx + 2'h1;
          case (q.param_idx)
            PARAM_START_HI, PARAM_END_HI: begin
              d.hi_bit = byte_in[MSB_BIT];
            end
            PARAM_START_LO: begin
              d.pend_start    = bound_in;
              d.pend_start_ok = bound_ok(bound_in,
                                         q.phase == DWC_COLUMN ? col_lim : page_lim);
            end
            default: begin
              // Both bounds commit together, each only if in range
              d.phase = DWC_IDLE;
              if (q.phase == DWC_COLUMN) begin
                if (q.pend_start_ok) begin
                  d.col_start = q.pend_start;
                end
                if (bound_ok(bound_in, col_lim)) begin
                  d.col_end = bound_in;
                end
              end else begin
                if (q.pend_start_ok) begin
                  d.page_start = q.pend_start;
                end
                if (bound_ok(bound_in, page_lim)) begin
                  d.page_end = bound_in;
                end
              end
            end
          endcase
        end
        DWC_STREAM: begin
          if (!q.win_done) begin
            d.pix_valid = 1'b1;
            d.pix_col   = q.cur_col;
            d.pix_page  = q.cur_page;
            d.pix_data  = host_data;
            if (!row_column_exchange_bit) begin
              if (col_last) begin
                d.cur_col = q.col_start;
                if (page_last) begin
                  d.win_done = 1'b1;
                end else begin
                  d.cur_page = step_addr(q.cur_page);
                end
              end else begin
                d.cur_col = step_addr(q.cur_col);
              end
            end else begin
              if (page_last) begin
                d.cur_page = q.page_start;
                if (col_last) begin
                  d.win_done = 1'b1;
                end else begin
                  d.cur_col = step_addr(q.cur_col);
                end
              end else begin
                d.cur_page = step_addr(q.cur_page);
              end
            end
          end
        end
        default: begin
          d.phase = DWC_IDLE;
        end
      endcase
    end

    if (soft_reset) begin
      d.phase      = DWC_IDLE;
      d.param_idx  = PARAM_START_HI;
      d.disp_on    = 1'b0;
      d.col_start  = START_RESET;
      d.col_end    = row_column_exchange_bit ? WIDE_END : NARROW_END;
      d.page_start = START_RESET;
      d.page_end   = row_column_exchange_bit ? NARROW_END : WIDE_END;
      d.pix_valid  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q               <= '0;
      q.wr_prev       <= 1'b1;
      q.phase         <= DWC_IDLE;
      q.disp_on       <= 1'b0;
      q.col_start     <= START_RESET;
      q.col_end       <= NARROW_END;
      q.page_start    <= START_RESET;
      q.page_end      <= WIDE_END;
      q.win_done      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign display_on   = q.disp_on;
  assign column_start = q.col_start;
  assign column_end   = q.col_end;
  assign page_start   = q.page_start;
  assign page_end     = q.page_end;
  assign stream_open  = q.phase == DWC_STREAM;
  assign pixel_valid  = q.pix_valid;
  assign pixel_column = q.pix_col;
  assign pixel_page   = q.pix_page;
  assign pixel_data   = q.pix_data;

endmodule : dwc_decoder

`default_nettype wire

// ### hw/dwc_pkg.sv
// Behaviour
// - Command 29h turns the panel output on; frame memory and status untouched.
// - Display-on while already on changes nothing.
// - All resets hold the panel output off until display-on arrives.
// - Display-on only changes panel drive; frame memory is preserved.
// - Command with select low, read strobe high, taken on write strobe rise.
// - Command 2Ah loads column window bounds; no status bits change.
// - Column parameters: start msb, start low byte, end msb, end low byte.
// - A column bound beyond frame memory is dropped; old value kept.
// - Hardware reset: column start 0, column end 013Fh.
// - Software reset: column start 0, end 013Fh or 01DFh per exchange bit.
// - Command 2Bh loads page window bounds; no status bits change.
// - Page parameters: start msb, start low byte, end msb, end low byte.
// - A page bound beyond frame memory is dropped; old value kept.
// - Hardware reset: page start 0, page end 01DFh.
// - Software reset: page start 0, end 01DFh or 013Fh per exchange bit.
// - These commands are accepted in every operating state.
// - Command 2Ch opens a pixel stream; each data word is one pixel.
// - Exchange 0: column advances, wraps to start, then page advances.
// - Exchange 1: page advances, wraps to start, then column advances.
// - Pixels beyond the window are dropped; a new command ends the stream.
`default_nettype none

package dwc_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 18;
  localparam int CMD_W  = 8;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_DISPLAY_ON = 8'h29;
  localparam logic [CMD_W-1:0] CMD_COLUMN_SET = 8'h2a;
  localparam logic [CMD_W-1:0] CMD_PAGE_SET   = 8'h2b;
  localparam logic [CMD_W-1:0] CMD_MEM_WRITE  = 8'h2c;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] START_RESET  = 9'h000;
  localparam logic [ADDR_W-1:0] NARROW_END   = 9'h13f;
  localparam logic [ADDR_W-1:0] WIDE_END     = 9'h1df;

  // ---------------------------------------------------------------
  // Parameter byte positions
  // ---------------------------------------------------------------
  localparam logic [1:0] PARAM_START_HI = 2'h0;
  localparam logic [1:0] PARAM_START_LO = 2'h1;
  localparam logic [1:0] PARAM_END_HI   = 2'h2;
  localparam logic [1:0] PARAM_END_LO   = 2'h3;
  localparam int         MSB_BIT        = 0;

  typedef enum logic [1:0] {
    DWC_IDLE,
    DWC_COLUMN,
    DWC_PAGE,
    DWC_STREAM
  } dwc_phase_t;

  typedef struct packed {
    logic              wr_prev;
    dwc_phase_t        phase;
    logic [1:0]        param_idx;
    logic              hi_bit;
    logic [ADDR_W-1:0] pend_start;
    logic              pend_start_ok;
    logic              disp_on;
    logic [ADDR_W-1:0] col_start;
    logic [ADDR_W-1:0] col_end;
    logic [ADDR_W-1:0] page_start;
    logic [ADDR_W-1:0] page_end;
    logic [ADDR_W-1:0] cur_col;
    logic [ADDR_W-1:0] cur_page;
    logic              win_done;
    logic              pix_valid;
    logic [ADDR_W-1:0] pix_col;
    logic [ADDR_W-1:0] pix_page;
    logic [DATA_W-1:0] pix_data;
  } dwc_state_t;

endpackage : dwc_pkg

`default_nettype wire

// ### testbench/display_window_cmd_decoder_test.sv
`default_nettype none
module display_window_cmd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dwc_pkg::*;
  logic core_clk, srst, soft_reset, row_column_exchange_bit;
  logic chip_select_n, data_command_select, read_strobe_n, write_strobe_n;
  logic [DATA_W-1:0] host_data, pixel_data;
  logic [ADDR_W-1:0] column_start, column_end, page_start, page_end, pixel_column, pixel_page;
  logic display_on, stream_open, pixel_valid;
  int miscompares = 0;
  int n_tests = 0;
  dwc_host_model i_host (.core_clk, .chip_select_n, .data_command_select,
    .read_strobe_n, .write_strobe_n, .host_data);
  dwc_decoder i_dut (.core_clk, .srst, .chip_select_n, .data_command_select,
    .read_strobe_n, .write_strobe_n, .host_data, .soft_reset, .row_column_exchange_bit,
    .display_on, .column_start, .column_end, .page_start, .page_end, .stream_open,
    .pixel_valid, .pixel_column, .pixel_page, .pixel_data);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ----------------
  // Helpers
  // ----------------
  task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic dc, input logic [17:0] d);
    i_host.send(dc, d, 1'b0, 1'b1);
    #1;
  endtask : wr
  task win(input logic [7:0] c, input logic [8:0] s, input logic [8:0] e);
    wr(1'b0, {10'h000, c});
    wr(1'b1, {17'h00000, s[8]});
    wr(1'b1, {10'h000, s[7:0]});
    wr(1'b1, {17'h00000, e[8]});
    wr(1'b1, {10'h000, e[7:0]});
  endtask : win
  task bounds(input logic [8:0] cs, input logic [8:0] ce, input logic [8:0] ps,
              input logic [8:0] pe);
    chk("column_start", column_start, cs);
    chk("column_end", column_end, ce);
    chk("page_start", page_start, ps);
    chk("page_end", page_end, pe);
  endtask : bounds
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ----------------
  // Scenarios
  // ----------------
  task t_display;
    chk("display_on", display_on, 1'b0);
    bounds(9'h000, 9'h13f, 9'h000, 9'h1df);
    i_host.send(1'b0, 18'h00029, 1'b1, 1'b1);
    i_host.send(1'b0, 18'h00029, 1'b0, 1'b0);
    #1 chk("display_on", display_on, 1'b0);
    wr(1'b0, 18'h00029);
    chk("display_on", display_on, 1'b1);
    wr(1'b0, 18'h00029);
    chk("display_on", display_on, 1'b1);
    bounds(9'h000, 9'h13f, 9'h000, 9'h1df);
  endtask : t_display
  task t_window;
    win(8'h2a, 9'h005, 9'h006);
    win(8'h2b, 9'h002, 9'h003);
    bounds(9'h005, 9'h006, 9'h002, 9'h003);
    win(8'h2a, 9'h140, 9'h007);
    win(8'h2b, 9'h001, 9'h1e0);
    bounds(9'h005, 9'h007, 9'h001, 9'h003);
    win(8'h2a, 9'h005, 9'h006);
    win(8'h2b, 9'h002, 9'h003);
    wr(1'b0, 18'h0002a);
    wr(1'b1, 18'h00000);
    wr(1'b1, 18'h00009);
    wr(1'b0, 18'h00029);
    bounds(9'h005, 9'h006, 9'h002, 9'h003);
  endtask : t_window
  task t_stream(input logic x);
    @(posedge core_clk) row_column_exchange_bit <= x;
    wr(1'b0, {10'h000, CMD_MEM_WRITE});
    chk("stream_open", stream_open, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(1'b1, 18'h2a5c3 ^ 18'(i));
      chk("pixel_valid", pixel_valid, i < 4);
      if (i < 4) begin
        chk("pixel_column", pixel_column, 9'h005 + (x ? i[1] : i[0]));
        chk("pixel_page", pixel_page, 9'h002 + (x ? i[0] : i[1]));
        chk("pixel_data", pixel_data, 18'h2a5c3 ^ 18'(i));
      end
    end
    wr(1'b0, 18'h00000);
    chk("stream_open", stream_open, 1'b0);
    wr(1'b1, 18'h00001);
    chk("pixel_valid", pixel_valid, 1'b0);
  endtask : t_stream
  // Hardware reset mid-run: defaults ignore the exchange bit, unlike soft reset
  task t_hard;
    chk("display_on", display_on, 1'b1);
    @(posedge core_clk) srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    #1 chk("display_on", display_on, 1'b0);
    bounds(9'h000, 9'h13f, 9'h000, 9'h1df);
  endtask : t_hard
  task t_soft;
    for (int x = 1; x >= 0; x--) begin
      @(posedge core_clk) row_column_exchange_bit <= x[0];
      @(posedge core_clk) soft_reset <= 1'b1;
      @(posedge core_clk) soft_reset <= 1'b0;
      #1 chk("display_on", display_on, 1'b0);
      bounds(9'h000, x ? 9'h1df : 9'h13f, 9'h000, x ? 9'h13f : 9'h1df);
      wr(1'b0, 18'h00029);
    end
  endtask : t_soft
  initial begin
    srst = 1'b1;
    soft_reset = 1'b0;
    row_column_exchange_bit = 1'b0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    t_display();
    t_window();
    t_stream(1'b0);
    t_stream(1'b1);
    t_hard();
    t_soft();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule : display_window_cmd_decoder_test
`default_nettype wire

// ### testbench/dwc_decoder_monitor.sv
`default_nettype none
module dwc_decoder_monitor
  import dwc_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              srst,
  // Host port and control
  input wire logic              chip_select_n,
  input wire logic              data_command_select,
  input wire logic              read_strobe_n,
  input wire logic              write_strobe_n,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic              soft_reset,
  input wire logic              row_column_exchange_bit,
  // Outputs
  input wire logic              display_on,
  input wire logic [ADDR_W-1:0] column_start,
  input wire logic [ADDR_W-1:0] column_end,
  input wire logic [ADDR_W-1:0] page_start,
  input wire logic [ADDR_W-1:0] page_end,
  input wire logic              stream_open,
  input wire logic              pixel_valid,
  input wire logic [ADDR_W-1:0] pixel_column,
  input wire logic [ADDR_W-1:0] pixel_page,
  input wire logic [DATA_W-1:0] pixel_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  logic on_q;
  logic upd_q;
  logic pix_q;
  logic tk;
  logic is_cmd;
  // Write taken: strobe seen low, now high, selected, read strobe idle
  assign tk = !chip_select_n && read_strobe_n && write_strobe_n && !prev_q;
  assign is_cmd = tk && !data_command_select;
  always_ff @(posedge core_clk) begin
    prev_q <= srst | write_strobe_n;
    on_q <= is_cmd && host_data[7:0] == CMD_DISPLAY_ON;
    upd_q <= srst | soft_reset | (tk && data_command_select);
    pix_q <= tk && data_command_select && stream_open && !soft_reset;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // ----------------
  // Assertions
  // ----------------
  chk_hw_defaults: assert property ($past(srst) |-> !display_on && !stream_open
    && column_start == START_RESET && column_end == NARROW_END
    && page_start == START_RESET && page_end == WIDE_END)
    else $error("state wrong after reset");
  chk_sw_defaults: assert property (soft_reset |=> !display_on
    && column_start == START_RESET && page_start == START_RESET
    && column_end == ($past(row_column_exchange_bit) ? WIDE_END : NARROW_END)
    && page_end == ($past(row_column_exchange_bit) ? NARROW_END : WIDE_END))
    else $error("state wrong after soft reset");
  chk_disp_cmd: assert property (is_cmd && host_data[7:0] == CMD_DISPLAY_ON
    && !soft_reset |=> display_on) else $error("display on not taken");
  chk_disp_hold: assert property (display_on && !soft_reset |=> display_on)
    else $error("display dropped");
  chk_disp_cause: assert property ($rose(display_on) |-> on_q)
    else $error("display rose without command");
  chk_bound_cause: assert property ($changed({column_start, column_end,
    page_start, page_end}) |-> upd_q) else $error("bounds changed without cause");
  chk_stream_start: assert property (is_cmd && host_data[7:0] == CMD_MEM_WRITE
    && !soft_reset |=> stream_open) else $error("stream not opened");
  chk_stream_end: assert property (is_cmd && host_data[7:0] != CMD_MEM_WRITE
    |=> !stream_open) else $error("stream not closed");
  chk_pixel_cause: assert property (pixel_valid |-> pix_q
    && pixel_data == $past(host_data)) else $error("pixel without data word");
  chk_pixel_window: assert property (pixel_valid |-> pixel_column >= column_start
    && pixel_column <= column_end && pixel_page >= page_start && pixel_page <= page_end)
    else $error("pixel outside window");
  cov_disp: cover property ($rose(display_on));
  cov_pixel: cover property (pixel_valid);
  cov_soft: cover property (soft_reset ##1 !display_on);
endmodule : dwc_decoder_monitor
bind dwc_decoder dwc_decoder_monitor i_mon (.core_clk, .srst, .chip_select_n,
  .data_command_select, .read_strobe_n, .write_strobe_n, .host_data, .soft_reset,
  .row_column_exchange_bit, .display_on, .column_start, .column_end, .page_start,
  .page_end, .stream_open, .pixel_valid, .pixel_column, .pixel_page, .pixel_data);
`default_nettype wire

// ### testbench/dwc_host_model.sv
`default_nettype none
module dwc_host_model (
  // Clock
  input wire logic         core_clk,
  // Host parallel port
  output var logic         chip_select_n,
  output var logic         data_command_select,
  output var logic         read_strobe_n,
  output var logic         write_strobe_n,
  output var logic [17:0]  host_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n = 1'b1;
    data_command_select = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_data = 18'h00000;
  end
  // One write: strobe low one cycle, high, taken at the following edge
  task send(input logic dc, input logic [17:0] d, input logic cs_n, input logic rd_n);
    @(posedge core_clk);
    chip_select_n <= cs_n;
    read_strobe_n <= rd_n;
    data_command_select <= dc;
    host_data <= d;
    write_strobe_n <= 1'b0;
    @(posedge core_clk);
    write_strobe_n <= 1'b1;
    @(posedge core_clk);
    chip_select_n <= 1'b1;
    host_data <= ~d;
  endtask : send
endmodule : dwc_host_model
`default_nettype wire
